// File: design/sync_guard_defines.svh
/*
 * Register offsets, field positions and timing counts of the sync guard and slew block.
 * Assumes a 250 MHz system clock and a 16-bit register address.
 */
`ifndef SYNC_GUARD_DEFINES_SVH
`define SYNC_GUARD_DEFINES_SVH

// ==========================================================
// Register offsets
`define SLEW_LIMIT_ADDR 16'h0D34
`define GUARD_CTRL_ADDR 16'h0D3C
`define SYNC_STATUS_ADDR 16'h0D40
`define RESTART_CTRL_ADDR 16'h0F08
`define PIN_CFG_ADDR 16'h0F10
`define IRQ_FLAGS_ADDR 16'h301D

// ==========================================================
// Field positions
`define BYPASS_UNLOCK_BIT 0
`define RESTART_BIT 0
`define STAT_READY_BIT 2
`define STAT_SLEW_BIT 6
`define STAT_ERR_BIT 7
`define IRQ_READY_BIT 0
`define IRQ_ERR_BIT 1
`define IRQ_SLEW_START_BIT 2
`define IRQ_SLEW_END_BIT 3

// ==========================================================
// Timing
`define CLK_PERIOD_PS 4000
`define SLEW_TICK_PS 244140625
`define STALL_CYCLES 3'h4
`define FILT_MAX_SHIFT 3'h4

`endif

// File: design/sync_guard_pkg.sv
/*
 * Types shared by the sync guard and slew block and its offset refiner.
 * Assumes sync_guard_defines.svh supplies the numeric constants.
 */
package sync_guard_pkg;

    typedef enum logic [1:0] {
        PIN_READY = 2'b00,
        PIN_ERROR = 2'b01,
        PIN_SLEW = 2'b10,
        PIN_OFF = 2'b11
    } pin_sel_t;

    typedef struct packed {
        logic [23:0] limit;
        logic bypass_unlock;
        pin_sel_t pin_sel;
        logic seen_first;
        logic init;
        logic first_apply;
        logic sync_err;
        logic slewing;
        logic restart;
        logic [2:0] stall;
        logic [15:0] tick;
        logic [3:0] irq;
        logic signed [31:0] target;
        logic signed [31:0] applied;
        logic [23:0] rdata;
        logic pin;
    } guard_state_t;

    typedef struct packed {
        logic [2:0] shift;
        logic signed [31:0] acc;
        logic valid;
    } refine_state_t;

endpackage : sync_guard_pkg

// File: design/offset_refiner.sv
/*
 * Offset refinement filter: exponential average whose shift grows with each event up to 4.
 * Assumes hold is high until initial synchronization and restart is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "sync_guard_defines.svh"

module offset_refiner
    import sync_guard_pkg::*;
(
    // Clock and reset
    input logic sys_clk,
    input logic reset,
    // Control
    input logic hold,
    input logic restart,
    // Offset in
    input logic in_valid,
    input logic signed [31:0] in_offset,
    // Offset out
    output logic out_valid,
    output logic signed [31:0] out_offset
);

    refine_state_t r;
    refine_state_t n;
    logic signed [32:0] diff;

    // ==========================================================
    // Filter
    always_comb begin
        n = r;
        n.valid = 1'b0;
        diff = {in_offset[31], in_offset} - {r.acc[31], r.acc};
        if (in_valid) begin
            if (r.shift == '0) begin
                n.acc = in_offset;
            end else begin
                n.acc = r.acc + 32'(diff >>> r.shift);
            end
            n.valid = 1'b1;
            if (r.shift != `FILT_MAX_SHIFT) begin
                n.shift = r.shift + 3'h1;
            end
        end
        // Restart keeps the average but lets the next event pass whole
        if (restart) begin
            n.shift = '0;
        end
        if (hold) begin
            n = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign out_valid = r.valid;
    assign out_offset = r.acc;

    first_pass_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (in_valid && r.shift == '0 && !hold) |=> (out_valid && out_offset == $past(in_offset))
    ) else $error("first offset after restart was altered");

endmodule : offset_refiner

// File: design/sync_offset_guard_slew.sv
/*
 * Guard switch, initial synchronization detect and slew limiter of the
 * common_clock_synchronizer, with its register port.
 * Assumes all inputs are synchronous to sys_clk and detector inputs are one-cycle pulses.
 */
// Overview of operation
// - Slew limiter after refinement turns phase steps into a bounded constant slope.
// - Limiting is active while the 24-bit limit field is nonzero, 2^-36 s/s units.
// - Writing zero to the limit bypasses the limiter at once.
// - A new nonzero limit stalls the limiter briefly, then slewing resumes.
// - First offset after initial synchronization passes unlimited; later ones are limited.
// - Status bit 6 reads one while the limiter is slewing.
// - Event bits 2 and 3 flag slewing start and end.
// - Slewing state can be routed to the multifunction status pin.
// - After restart the next offset passes unfiltered, later ones filtered more, down to a 1/16 weight.
// - Restart is not initial synchronization; the next event is still limited.
// - A guard event discards the latest offset before refinement.
// - After initial sync, unlock, magnitude or latency detection trips the guard.
// - Any guard trip raises synchronization error, status bit 7.
// - Synchronization error also sets event bit 1.
// - Guard control bit 0 set suppresses loop unlock as a guard trigger.
// - Before initial sync, refinement and slew limiter are held in reset.
// - Initial sync needs a stable system clock and a second event; detectors are not checked before it.
// - Status bit 2 reads one when the common time scale is ready.
// - Readiness also sets event bit 0 and can drive the status pin.
// - First event after reset flags sync error; the next valid event clears it.
`timescale 1ns/1ps
`include "sync_guard_defines.svh"

module sync_offset_guard_slew
    import sync_guard_pkg::*;
#(
    parameter int SLEW_TICK_CYCLES = `SLEW_TICK_PS / `CLK_PERIOD_PS
)
(
    // Clock and reset
    input logic sys_clk,
    input logic reset,
    // Register port
    input logic [15:0] reg_addr,
    input logic [23:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [23:0] reg_rdata,
    // Synchronizer events
    input logic sync_event,
    input logic signed [31:0] sync_offset,
    input logic loop_unlocked,
    input logic sysclk_stable,
    input logic mag_detect,
    input logic latency_detect,
    // Time scale and status
    output logic signed [31:0] time_adjust,
    output logic ready,
    output logic sync_error,
    output logic slewing,
    output logic multifunction_status_pin
);

    localparam logic [15:0] TICK_LAST = 16'(SLEW_TICK_CYCLES - 1);

    guard_state_t s;
    guard_state_t n;

    logic guard_event;
    logic declare;
    logic accepted;
    logic filt_hold;
    logic filt_valid;
    logic signed [31:0] filt_out;
    logic slew_tick;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic signed [32:0] diff;
    logic signed [32:0] lim33;
    logic signed [31:0] step;

    // ==========================================================
    // Guard and initial synchronization
    // Unlock only counts when an event is there to discard; latency trips alone
    assign guard_event = s.init && (latency_detect || (sync_event &&
        ((loop_unlocked && !s.bypass_unlock) || mag_detect)));
    assign declare = !s.init && s.seen_first && sync_event && sysclk_stable;
    assign accepted = sync_event && !guard_event && (s.init || declare);
    assign filt_hold = !(s.init || declare);
    assign slew_tick = (s.tick == TICK_LAST);

    offset_refiner refiner (
        .sys_clk(sys_clk),
        .reset(reset),
        .hold(filt_hold),
        .restart(s.restart),
        .in_valid(accepted),
        .in_offset(sync_offset),
        .out_valid(filt_valid),
        .out_offset(filt_out)
    );

    // ==========================================================
    // Next state
    always_comb begin
        n = s;
        n.restart = 1'b0;
        n.rdata = '0;
        irq_clr = '0;
        diff = '0;
        lim33 = '0;
        step = '0;
        n.tick = slew_tick ? '0 : s.tick + 16'h0001;
        if (s.stall != '0) begin
            n.stall = s.stall - 3'h1;
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `SLEW_LIMIT_ADDR) begin
                n.limit = reg_wdata;
                if (reg_wdata != '0) begin
                    n.stall = `STALL_CYCLES;
                end
            end else if (reg_addr == `GUARD_CTRL_ADDR) begin
                n.bypass_unlock = reg_wdata[`BYPASS_UNLOCK_BIT];
            end else if (reg_addr == `RESTART_CTRL_ADDR) begin
                n.restart = reg_wdata[`RESTART_BIT];
            end else if (reg_addr == `PIN_CFG_ADDR) begin
                n.pin_sel = pin_sel_t'(reg_wdata[1:0]);
            end
        end

        // Register reads; event flags clear on read
        if (reg_rd) begin
            if (reg_addr == `SLEW_LIMIT_ADDR) begin
                n.rdata = s.limit;
            end else if (reg_addr == `GUARD_CTRL_ADDR) begin
                n.rdata[`BYPASS_UNLOCK_BIT] = s.bypass_unlock;
            end else if (reg_addr == `SYNC_STATUS_ADDR) begin
                n.rdata[`STAT_READY_BIT] = s.init;
                n.rdata[`STAT_SLEW_BIT] = s.slewing;
                n.rdata[`STAT_ERR_BIT] = s.sync_err;
            end else if (reg_addr == `PIN_CFG_ADDR) begin
                n.rdata[1:0] = s.pin_sel;
            end else if (reg_addr == `IRQ_FLAGS_ADDR) begin
                n.rdata[3:0] = s.irq;
                irq_clr = s.irq;
            end
        end

        // Initial synchronization; a restart never touches these flags
        if (sync_event && !s.init) begin
            if (!s.seen_first) begin
                n.seen_first = 1'b1;
                n.sync_err = 1'b1;
            end else if (declare) begin
                n.init = 1'b1;
                n.sync_err = 1'b0;
                n.first_apply = 1'b1;
            end
        end
        if (guard_event) begin
            n.sync_err = 1'b1;
        end else if (accepted && s.init) begin
            n.sync_err = 1'b0;
        end

        // Slew limiter
        if (filt_valid) begin
            n.target = filt_out;
            if (s.first_apply) begin
                n.applied = filt_out;
                n.first_apply = 1'b0;
            end
        end
        diff = {n.target[31], n.target} - {s.applied[31], s.applied};
        lim33 = $signed({9'h000, n.limit});
        if (diff > lim33) begin
            step = $signed({8'h00, n.limit});
        end else if (diff < -lim33) begin
            step = -$signed({8'h00, n.limit});
        end else begin
            step = diff[31:0];
        end
        if (n.limit == '0) begin
            n.applied = n.target;
        end else if (slew_tick && s.stall == '0 && !(filt_valid && s.first_apply)) begin
            n.applied = s.applied + step;
        end
        if (!n.init) begin
            n.target = '0;
            n.applied = '0;
        end
        n.slewing = (n.applied != n.target);

        // Event flags: a new event wins over a clear by read
        irq_set[`IRQ_READY_BIT] = !s.init && n.init;
        irq_set[`IRQ_ERR_BIT] = !s.sync_err && n.sync_err;
        irq_set[`IRQ_SLEW_START_BIT] = !s.slewing && n.slewing;
        irq_set[`IRQ_SLEW_END_BIT] = s.slewing && !n.slewing;
        n.irq = (s.irq & ~irq_clr) | irq_set;

        case (n.pin_sel)
            PIN_READY: n.pin = n.init;
            PIN_ERROR: n.pin = n.sync_err;
            PIN_SLEW: n.pin = n.slewing;
            default: n.pin = 1'b0;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign time_adjust = s.applied;
    assign ready = s.init;
    assign sync_error = s.sync_err;
    assign slewing = s.slewing;
    assign multifunction_status_pin = s.pin;

    // ==========================================================
    // Checks
    logic signed [31:0] time_adjust_prev;
    logic signed [32:0] moved;
    assign moved = {s.applied[31], s.applied} - {time_adjust_prev[31], time_adjust_prev};
    always_ff @(posedge sys_clk) begin
        time_adjust_prev <= s.applied;
    end

    step_bound_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (s.init && $past(s.init) && s.limit != '0 && $past(s.limit) != '0
            && !$past(s.first_apply))
        |-> (moved <= $signed({9'h000, s.limit}) && moved >= -$signed({9'h000, s.limit}))
    ) else $error("phase moved faster than the slew limit");

    bypass_zero_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (s.limit == '0) |-> (s.applied == s.target && !s.slewing)
    ) else $error("zero limit did not bypass the limiter");

    stall_hold_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == `SLEW_LIMIT_ADDR && reg_wdata != '0 && s.init && !filt_valid)
        ##1 (!reg_wr && !filt_valid) |-> ##1 $stable(s.applied)
    ) else $error("limiter moved during stall");

    first_apply_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (s.first_apply && filt_valid) |=> (s.applied == $past(filt_out) && !s.first_apply)
    ) else $error("first offset was not applied whole");

    slew_irq_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        ($rose(s.slewing) |-> s.irq[`IRQ_SLEW_START_BIT])
        and ($fell(s.slewing) |-> (s.irq[`IRQ_SLEW_END_BIT] && s.applied == s.target))
    ) else $error("slew start or end flag missing");

    guard_block_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        guard_event |-> (!accepted ##1 s.sync_err)
    ) else $error("guarded offset reached refinement");

    unlock_trip_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (s.init && sync_event && loop_unlocked && !s.bypass_unlock) |-> ##1 s.sync_err
    ) else $error("unlock did not trip the guard");

    hold_reset_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        !s.init |-> (s.applied == '0 && !filt_valid && !s.slewing)
    ) else $error("stages not held before initial sync");

    ready_irq_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $rose(s.init) |-> (s.irq[`IRQ_READY_BIT] && !s.sync_err)
    ) else $error("ready event missing");

    first_err_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (sync_event && !s.seen_first) |=> (s.sync_err && !s.init)
    ) else $error("first event did not flag an error");

    bypass_unlock_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (s.init && sync_event && loop_unlocked && s.bypass_unlock && !mag_detect
            && !latency_detect) |=> !s.sync_err
    ) else $error("unlock tripped the guard while bypassed");

    mag_trip_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (s.init && sync_event && mag_detect) |=> s.sync_err
    ) else $error("magnitude detection did not trip the guard");

    latency_trip_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (s.init && latency_detect) |=> s.sync_err
    ) else $error("latency detection did not trip the guard");

    err_irq_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $rose(s.sync_err) |-> s.irq[`IRQ_ERR_BIT]
    ) else $error("error event flag missing");

    // Status bits are taken from the state of the read cycle itself
    status_read_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == `SYNC_STATUS_ADDR)
        |=> (reg_rdata[`STAT_SLEW_BIT] == $past(s.slewing)
            && reg_rdata[`STAT_ERR_BIT] == $past(s.sync_err)
            && reg_rdata[`STAT_READY_BIT] == $past(s.init))
    ) else $error("status read does not match the state");

    pin_route_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        ((s.pin_sel == PIN_SLEW) |-> (multifunction_status_pin == s.slewing))
        and ((s.pin_sel == PIN_READY) |-> (multifunction_status_pin == s.init))
    ) else $error("status pin does not follow its selection");

    // A restart must never reopen the unlimited first apply
    first_only_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $rose(s.first_apply) |-> $rose(s.init)
    ) else $error("unlimited apply outside initial sync");

    ready_cause_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $rose(s.init) |-> $past(sync_event && sysclk_stable && s.seen_first)
    ) else $error("ready without a stable clock and a second event");

    stall_load_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == `SLEW_LIMIT_ADDR && reg_wdata != '0)
        |=> (s.stall == `STALL_CYCLES)
    ) else $error("new limit did not stall the limiter");

    restart_pulse_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == `RESTART_CTRL_ADDR && reg_wdata[`RESTART_BIT]) |=> s.restart
    ) else $error("restart write did not reach the refiner");

endmodule : sync_offset_guard_slew

// File: bench/tb.sv
/*
 * Self-checking bench for the sync guard and slew block: register reads and writes,
 * synchronizer events, guard trips, restart and slew limiting.
 * Assumes sync_guard_defines.svh is on the include path; the slew tick is shortened to 8.
 */
`timescale 1ns/1ps
`include "sync_guard_defines.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_errors++; $display("Error %s expected %0h seen %0h", nm, ex, gt); end end

module tb;
    // ==========================================================
    // Signals
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [15:0] reg_addr = 16'h0;
    logic [23:0] reg_wdata = 24'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [23:0] reg_rdata;
    logic sync_event = 1'h0;
    logic signed [31:0] sync_offset = 32'h0;
    logic loop_unlocked = 1'h0;
    logic sysclk_stable = 1'h0;
    logic mag_detect = 1'h0;
    logic latency_detect = 1'h0;
    logic signed [31:0] time_adjust;
    logic ready;
    logic sync_error;
    logic slewing;
    logic multifunction_status_pin;
    logic [23:0] rv;
    int n_errors = 0;
    int check_count = 0;

    always #2 sys_clk = ~sys_clk;

    sync_offset_guard_slew #(.SLEW_TICK_CYCLES(8)) dut_u (
        .sys_clk(sys_clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .sync_event(sync_event),
        .sync_offset(sync_offset),
        .loop_unlocked(loop_unlocked),
        .sysclk_stable(sysclk_stable),
        .mag_detect(mag_detect),
        .latency_detect(latency_detect),
        .time_adjust(time_adjust),
        .ready(ready),
        .sync_error(sync_error),
        .slewing(slewing),
        .multifunction_status_pin(multifunction_status_pin)
    );

    // ==========================================================
    // Bus and event tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [15:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask : wr

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [23:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rchk(input logic [15:0] a, input logic [23:0] ex, input string nm);
        rd(a, rv);
        `CHK(nm, ex, rv)
    endtask : rchk

    // Detector bits: 0 magnitude, 1 unlock, 2 latency
    task automatic ev(input logic [31:0] off, input logic se, input logic [2:0] det);
        @(posedge sys_clk);
        sync_event <= se;
        sync_offset <= off;
        mag_detect <= det[0];
        loop_unlocked <= det[1];
        latency_detect <= det[2];
        @(posedge sys_clk);
        sync_event <= 1'h0;
        mag_detect <= 1'h0;
        loop_unlocked <= 1'h0;
        latency_detect <= 1'h0;
    endtask : ev

    // Follows the slew each cycle; a step above the limit of 16 would be a frequency impulse
    task automatic settle(input logic [31:0] fin);
        logic signed [31:0] prev;
        int n;
        prev = time_adjust;
        n = 0;
        while (slewing === 1'h1 && n < 600) begin
            cyc(1);
            `CHK("slew step", 1'h1, (time_adjust - prev <= 16) && (prev - time_adjust <= 16))
            prev = time_adjust;
            n++;
        end
        `CHK("settled adjust", fin, time_adjust)
        `CHK("slewing done", 1'h0, slewing)
    endtask : settle

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Tests
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'h0;
        cyc(1);
        `CHK("ready at reset", 1'h0, ready)
        `CHK("adjust at reset", 32'h0, time_adjust)
        rchk(`SLEW_LIMIT_ADDR, 24'h0, "limit reset");
        rchk(`GUARD_CTRL_ADDR, 24'h0, "guard ctrl reset");
        rchk(`SYNC_STATUS_ADDR, 24'h0, "status reset");
        rchk(16'h1234, 24'h0, "unmapped read");
        wr(`SLEW_LIMIT_ADDR, 24'h000010);
        rchk(`SLEW_LIMIT_ADDR, 24'h000010, "limit readback");
        @(posedge sys_clk);
        sysclk_stable <= 1'h1;
        ev(32'h1000, 1'h1, 3'h0);
        cyc(2);
        `CHK("first event error", 1'h1, sync_error)
        `CHK("not ready yet", 1'h0, ready)
        `CHK("held adjust", 32'h0, time_adjust)
        @(posedge sys_clk);
        sysclk_stable <= 1'h0;
        ev(32'h1000, 1'h1, 3'h0);
        cyc(2);
        `CHK("unstable clock", 1'h0, ready)
        @(posedge sys_clk);
        sysclk_stable <= 1'h1;
        ev(32'h1000, 1'h1, 3'h0);
        cyc(3);
        `CHK("ready", 1'h1, ready)
        `CHK("error cleared", 1'h0, sync_error)
        `CHK("first apply", 32'h1000, time_adjust)
        `CHK("ready pin", 1'h1, multifunction_status_pin)
        rchk(`IRQ_FLAGS_ADDR, 24'h000003, "irq init");
        rchk(`IRQ_FLAGS_ADDR, 24'h0, "irq cleared");
        $display("Test init done");

        // Second offset is averaged by half: 0x1000 + (0x1080 - 0x1000) / 2
        ev(32'h1080, 1'h1, 3'h0);
        cyc(3);
        `CHK("slewing", 1'h1, slewing)
        `CHK("no jump", 1'h1, time_adjust !== 32'h1040)
        rchk(`SYNC_STATUS_ADDR, 24'h000044, "status slewing");
        settle(32'h1040);
        rchk(`IRQ_FLAGS_ADDR, 24'h00000C, "irq slew");
        rchk(`SYNC_STATUS_ADDR, 24'h000004, "status idle");
        $display("Test slew done");

        // Third offset weighted by a quarter; zero limit must cut the slew short
        ev(32'h1440, 1'h1, 3'h0);
        cyc(20);
        `CHK("slewing long", 1'h1, slewing)
        wr(`SLEW_LIMIT_ADDR, 24'h0);
        cyc(2);
        `CHK("bypass adjust", 32'h1140, time_adjust)
        cyc(2);
        `CHK("bypass idle", 1'h0, slewing)
        $display("Test bypass done");

        wr(`RESTART_CTRL_ADDR, 24'h000001);
        rchk(`RESTART_CTRL_ADDR, 24'h0, "restart reads zero");
        wr(`SLEW_LIMIT_ADDR, 24'h000010);
        wr(`PIN_CFG_ADDR, 24'h000002);
        cyc(8);
        ev(32'h1160, 1'h1, 3'h0);
        cyc(3);
        `CHK("restart limited", 1'h1, slewing)
        `CHK("restart no jump", 1'h1, time_adjust !== 32'h1160)
        cyc(1);
        `CHK("slew pin", 1'h1, multifunction_status_pin)
        settle(32'h1160);
        cyc(1);
        `CHK("slew pin idle", 1'h0, multifunction_status_pin)
        $display("Test restart done");

        wr(`PIN_CFG_ADDR, 24'h000001);
        for (int k = 0; k < 3; k++) begin
            ev(32'h9999, k != 2, 3'h1 << k);
            cyc(3);
            `CHK("guard error", 1'h1, sync_error)
            `CHK("error pin", 1'h1, multifunction_status_pin)
            `CHK("offset dropped", 32'h1160, time_adjust)
            rd(`IRQ_FLAGS_ADDR, rv);
            `CHK("irq error", 1'h1, rv[1])
            ev(32'h1160, 1'h1, 3'h0);
            cyc(3);
            `CHK("valid clears", 1'h0, sync_error)
        end
        wr(`GUARD_CTRL_ADDR, 24'h000001);
        rchk(`GUARD_CTRL_ADDR, 24'h000001, "bypass readback");
        ev(32'h1160, 1'h1, 3'h2);
        cyc(3);
        `CHK("unlock ignored", 1'h0, sync_error)
        wr(`PIN_CFG_ADDR, 24'h000000);
        cyc(1);
        `CHK("ready pin again", 1'h1, multifunction_status_pin)
        wr(`PIN_CFG_ADDR, 24'h000003);
        rchk(`PIN_CFG_ADDR, 24'h000003, "pin cfg readback");
        `CHK("pin off", 1'h0, multifunction_status_pin)
        $display("Test guard done");
        complete_run();
    end

    // A hung wait would otherwise run forever; all tests need far fewer cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("Error watchdog expected finish seen timeout");
        complete_run();
    end
endmodule : tb
